// ---- verilog/sme_pkg.sv ----
// Constants for the serial EEPROM master: timing, frame layout, commands.
// Assumes a 200 MHz system clock and an SPI mode 0 EEPROM slave.
package sme_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned SCK_HZ = 2_000_000;
  // Half period of the serial clock in system cycles
  localparam int unsigned SCK_HALF_CYC = CLK_HZ / (2 * SCK_HZ);
  // Least idle time between frames: one bit period
  localparam int unsigned GAP_NS = 500;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned GAP_CYC =
    (GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
  localparam logic [7:0] ARRAY_WRITE_CMD = 8'h02;

  localparam logic [5:0] LEN_CMD = 6'h08;
  localparam logic [5:0] LEN_STATUS = 6'h10;
  localparam logic [5:0] LEN_DATA = 6'h20;

  localparam int unsigned WRITE_BUSY_BIT = 0;
  localparam int unsigned WRITE_LATCH_BIT = 1;
  localparam int unsigned ADDR_W = 13;
  localparam logic [12:0] ADDR_MAX = 13'h1fff;

  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned FIFO_WIDTH = 8;

  typedef enum logic [2:0] {
    OP_WRITE_BYTE = 3'h0,
    OP_READ_BYTE = 3'h1,
    OP_STATUS_READ = 3'h2,
    OP_STATUS_WRITE = 3'h3,
    OP_WRITE_DISABLE = 3'h4
  } sme_op_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LATCH_ON = 3'b001,
    ST_CHECK = 3'b011,
    ST_WRITE = 3'b010,
    ST_POLL = 3'b110,
    ST_READ = 3'b111,
    ST_PUSH = 3'b101
  } sme_state_type;
endpackage

// ---- verilog/sme_eeprom_master.sv ----
// Serial EEPROM master: operation sequencer, frame shifter, result FIFO.
// Assumes one EEPROM slave on the link, mode 0, clk at 200 MHz.
`timescale 1ns/10ps

module sme_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// Contract
// - Unit is sole master, drives select, clock
// - Serial clock 2 MHz from divided system clock
// - Separate data out and data in pins
// - Frames: 8, 16, or 32 bits by command
// - Done flag after final bit shifted out
// - Write enable 06, write disable 04
// - Status read 05, status write 01
// - Array read command 03 returns data
// - Array write command 02 stores data
// - Byte addresses span 0000 to 1fff
// - Write: enable, check latch, write, poll busy
// - Slot load clears empty flag; move sets
// - Wait one bit period between frames
module sme_eeprom_master
  import sme_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic op_valid,
  output logic op_ready,
  input wire logic [2:0] op_code,
  input wire logic [12:0] op_addr,
  input wire logic [7:0] op_data,
  output logic op_fail,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  output logic tx_done_flag,
  output logic tx_buffer_empty_flag,
  output logic chip_select_line_n,
  output logic serial_clock_line,
  output logic serial_data_out,
  input wire logic serial_data_in
);
  sme_state_type state_q;
  logic [2:0] op_q;
  logic [12:0] addr_q;
  logic [7:0] data_q;
  logic issued_q;
  logic fail_q;
  logic din_s1_q;
  logic din_s2_q;
  logic [31:0] slot_q;
  logic [5:0] slot_len_q;
  logic tbe_q;
  logic [31:0] sh_q;
  logic [31:0] rx_q;
  logic [5:0] bits_q;
  logic [7:0] half_q;
  logic busy_q;
  logic sck_q;
  logic cs_n_q;
  logic done_q;
  logic txd_q;
  logic [7:0] gap_q;
  logic [31:0] frame_word;
  logic [5:0] frame_len;
  logic load_frame;
  logic can_start;
  logic push_valid;
  logic push_ready;
  logic [7:0] rx_byte;

  assign rx_byte = rx_q[7:0];
  assign op_ready = (state_q == ST_IDLE);
  assign op_fail = fail_q;
  assign tx_done_flag = txd_q;
  assign tx_buffer_empty_flag = tbe_q;
  assign chip_select_line_n = cs_n_q;
  assign serial_clock_line = sck_q;
  assign serial_data_out = sh_q[31];
  assign push_valid = (state_q == ST_PUSH);

  // Data in passes two flops before use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      din_s1_q <= 1'b0;
      din_s2_q <= 1'b0;
    end else begin
      din_s1_q <= serial_data_in;
      din_s2_q <= din_s1_q;
    end
  end

  // Frame contents per sequencer state
  always_comb begin
    frame_word = '0;
    frame_len = LEN_CMD;
    case (state_q)
      ST_LATCH_ON: begin
        frame_word = {WRITE_ENABLE_CMD, 24'h0};
        frame_len = LEN_CMD;
      end
      ST_CHECK, ST_POLL: begin
        frame_word = {STATUS_READ_CMD, 24'h0};
        frame_len = LEN_STATUS;
      end
      ST_WRITE: begin
        if (op_q == OP_STATUS_WRITE) begin
          frame_word = {STATUS_WRITE_CMD, data_q, 16'h0};
          frame_len = LEN_STATUS;
        end else begin
          frame_word = {ARRAY_WRITE_CMD, 3'h0, addr_q, data_q};
          frame_len = LEN_DATA;
        end
      end
      ST_READ: begin
        if (op_q == OP_STATUS_READ) begin
          frame_word = {STATUS_READ_CMD, 24'h0};
          frame_len = LEN_STATUS;
        end else if (op_q == OP_WRITE_DISABLE) begin
          frame_word = {WRITE_DISABLE_CMD, 24'h0};
          frame_len = LEN_CMD;
        end else begin
          frame_word = {ARRAY_READ_CMD, 3'h0, addr_q, 8'h00};
          frame_len = LEN_DATA;
        end
      end
      default: begin
        frame_word = '0;
        frame_len = LEN_CMD;
      end
    endcase
  end

  // Next frame only once the link has idled a bit period
  assign can_start = !issued_q && tbe_q && !busy_q && !done_q &&
                     (gap_q == '0);
  assign load_frame = can_start && (state_q != ST_IDLE) &&
                      (state_q != ST_PUSH);

  // Transmit slot and its empty flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_q <= '0;
      slot_len_q <= LEN_CMD;
      tbe_q <= 1'b1;
    end else if (load_frame) begin
      slot_q <= frame_word;
      slot_len_q <= frame_len;
      tbe_q <= 1'b0;
    end else if (!tbe_q && !busy_q) begin
      tbe_q <= 1'b1;
    end
  end

  // Shifter: mode 0, sample on rise, shift on fall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_q <= '0;
      rx_q <= '0;
      bits_q <= '0;
      half_q <= '0;
      busy_q <= 1'b0;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!tbe_q && !busy_q) begin
        sh_q <= slot_q;
        bits_q <= slot_len_q;
        half_q <= '0;
        busy_q <= 1'b1;
        sck_q <= 1'b0;
        cs_n_q <= 1'b0;
      end else if (busy_q) begin
        if (half_q == 8'(SCK_HALF_CYC - 1)) begin
          half_q <= '0;
          if (!sck_q) begin
            sck_q <= 1'b1;
            rx_q <= {rx_q[30:0], din_s2_q};
          end else begin
            sck_q <= 1'b0;
            sh_q <= {sh_q[30:0], 1'b0};
            bits_q <= bits_q - 1'b1;
            if (bits_q == 6'h01) begin
              busy_q <= 1'b0;
              cs_n_q <= 1'b1;
              done_q <= 1'b1;
            end
          end
        end else begin
          half_q <= half_q + 1'b1;
        end
      end
    end
  end

  // Transmit-done flag: set after last bit, cleared on next load
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txd_q <= 1'b0;
    end else if (done_q) begin
      txd_q <= 1'b1;
    end else if (load_frame) begin
      txd_q <= 1'b0;
    end
  end

  // Gap counter between frames
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_q <= '0;
    end else if (done_q) begin
      gap_q <= 8'(GAP_CYC);
    end else if (gap_q != '0) begin
      gap_q <= gap_q - 1'b1;
    end
  end

  // Failure flag: latch not confirmed set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fail_q <= 1'b0;
    end else if (state_q == ST_CHECK && done_q &&
                 !rx_byte[WRITE_LATCH_BIT]) begin
      fail_q <= 1'b1;
    end else if (op_valid && op_ready) begin
      fail_q <= 1'b0;
    end
  end

  // Operation sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      op_q <= OP_WRITE_BYTE;
      addr_q <= '0;
      data_q <= '0;
      issued_q <= 1'b0;
    end else begin
      if (load_frame) begin
        issued_q <= 1'b1;
      end else if (done_q) begin
        issued_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          if (op_valid) begin
            op_q <= op_code;
            addr_q <= op_addr & ADDR_MAX;
            data_q <= op_data;
            if (op_code == OP_WRITE_BYTE || op_code == OP_STATUS_WRITE) begin
              state_q <= ST_LATCH_ON;
            end else begin
              state_q <= ST_READ;
            end
          end
        end
        ST_LATCH_ON: begin
          if (done_q) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (done_q) begin
            state_q <= rx_byte[WRITE_LATCH_BIT] ? ST_WRITE : ST_IDLE;
          end
        end
        ST_WRITE: begin
          if (done_q) begin
            state_q <= ST_POLL;
          end
        end
        ST_POLL: begin
          if (done_q && !rx_byte[WRITE_BUSY_BIT]) begin
            state_q <= ST_IDLE;
          end
        end
        ST_READ: begin
          if (done_q) begin
            state_q <= (op_q == OP_WRITE_DISABLE) ? ST_IDLE : ST_PUSH;
          end
        end
        ST_PUSH: begin
          if (push_ready) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  sme_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(rx_byte),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );
endmodule

// ---- test/sme_master_properties.sv ----
// Port checker for the serial EEPROM master.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/10ps
module sme_master_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [7:0] rd_data,
  input wire logic tx_done_flag,
  input wire logic tx_buffer_empty_flag,
  input wire logic chip_select_line_n,
  input wire logic serial_clock_line,
  input wire logic serial_data_out
);
  logic sck_q;
  logic [7:0] hi_q;
  logic [7:0] gap_q;
  logic [5:0] nb_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // High time of sck, idle time of select, bits per frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_q <= 1'b0;
      hi_q <= 8'h00;
      gap_q <= 8'hff;
      nb_q <= 6'h00;
    end else begin
      sck_q <= serial_clock_line;
      hi_q <= serial_clock_line ? hi_q + 8'h01 : 8'h00;
      gap_q <= chip_select_line_n ? gap_q + {7'h0, gap_q != 8'hff} : 8'h00;
      nb_q <= chip_select_line_n ? 6'h00 :
        nb_q + {5'h0, serial_clock_line & !sck_q};
    end
  end
  sequence s_taken;
    op_valid && op_ready;
  endsequence
  sequence s_load;
    $fell(tx_buffer_empty_flag);
  endsequence
  property p_sck_sel;
    serial_clock_line |-> !chip_select_line_n;
  endproperty
  a_sck_sel: assert property (p_sck_sel)
    else $error("sck high while deselected");
  property p_half;
    $fell(serial_clock_line) |-> hi_q == 8'h32;
  endproperty
  a_half: assert property (p_half)
    else $error("sck high time wrong");
  property p_len;
    $rose(chip_select_line_n) |-> nb_q inside {6'h08, 6'h10, 6'h20};
  endproperty
  a_len: assert property (p_len)
    else $error("frame length wrong");
  property p_done;
    $rose(chip_select_line_n) |=> tx_done_flag;
  endproperty
  a_done: assert property (p_done)
    else $error("done flag late");
  property p_tbe;
    s_load |=> tx_buffer_empty_flag && !chip_select_line_n;
  endproperty
  a_tbe: assert property (p_tbe)
    else $error("empty flag not restored");
  property p_gap;
    $fell(chip_select_line_n) |-> gap_q >= 8'h64;
  endproperty
  a_gap: assert property (p_gap)
    else $error("frame gap too short");
  property p_sdo;
    !chip_select_line_n && !$fell(chip_select_line_n) &&
      $changed(serial_data_out) |-> $fell(serial_clock_line);
  endproperty
  a_sdo: assert property (p_sdo)
    else $error("data out moved off falling sck");
  property p_take;
    s_taken |=> !op_ready[*2];
  endproperty
  a_take: assert property (p_take)
    else $error("ready after take");
  property p_hold;
    rd_valid && !rd_ready |=> rd_valid && $stable(rd_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("result dropped");
endmodule
bind sme_eeprom_master sme_master_properties u_props (
  .clk(clk),
  .rst(rst),
  .op_valid(op_valid),
  .op_ready(op_ready),
  .rd_valid(rd_valid),
  .rd_ready(rd_ready),
  .rd_data(rd_data),
  .tx_done_flag(tx_done_flag),
  .tx_buffer_empty_flag(tx_buffer_empty_flag),
  .chip_select_line_n(chip_select_line_n),
  .serial_clock_line(serial_clock_line),
  .serial_data_out(serial_data_out)
);

// ---- test/sme_eeprom_model.sv ----
// Behavioural serial EEPROM, 8K bytes, mode 0, one busy status poll.
// Assumes its write-protect pin is held high.
`timescale 1ns/10ps
module sme_eeprom_model (
  input wire logic cs_n,
  input wire logic sck,
  input wire logic din,
  input wire logic latch_deaf,
  output logic dout
);
  logic [7:0] mem [0:8191];
  logic [7:0] sr, tx;
  logic [31:0] rx;
  logic [12:0] a;
  int n, busy;
  initial begin
    sr = 8'h00;
    dout = 1'b0;
    tx = 8'h00;
    busy = 0;
    for (int i = 0; i < 8192; i++) mem[i] = 8'hff;
  end
  always @(negedge cs_n) n = 0;
  always @(posedge sck) if (!cs_n) begin
    rx = {rx[30:0], din};
    n++;
    if (n == 8) tx = rx[7:0] == 8'h05 ? sr : 8'h00;
    if (n == 24 && rx[23:16] == 8'h03) tx = mem[rx[12:0]];
  end
  always @(negedge sck) if (!cs_n) begin
    dout = tx[7];
    tx = {tx[6:0], 1'b0};
  end
  // Released line shows the inverse of its last value
  always @(posedge cs_n) begin
    dout = ~dout;
    a = rx[20:8];
    if (n == 8 && rx[7:0] == 8'h06 && !latch_deaf) sr[1] = 1'b1;
    if (n == 8 && rx[7:0] == 8'h04) sr[1] = 1'b0;
    if (n == 16 && rx[15:8] == 8'h05 && busy > 0) begin
      busy--;
      sr[1:0] = 2'h0;
    end
    if (n == 16 && rx[15:8] == 8'h01 && sr[1]) begin
      sr = {rx[7], 3'h0, rx[3:2], 2'h3};
      busy = 1;
    end
    if (n == 32 && rx[31:24] == 8'h02 && sr[1]) begin
      if (!(sr[3:2] == 2'h3 || sr[3:2] == 2'h2 && a[12] ||
          sr[3:2] == 2'h1 && a[12:11] == 2'h3)) mem[a] = rx[7:0];
      sr[0] = 1'b1;
      busy = 1;
    end
  end
endmodule

// ---- test/tb.sv ----
// Self-checking bench: master against the EEPROM model.
// Assumes a 200 MHz clock and the model's single busy poll.
`timescale 1ns/10ps
module tb;
  import sme_pkg::*;
  logic clk, rst, op_valid, rd_ready, deaf, op_ready, op_fail, rd_valid;
  logic [2:0] op_code;
  logic [12:0] op_addr;
  logic [7:0] op_data, rd_data;
  logic tx_done_flag, tx_buffer_empty_flag, chip_select_line_n;
  logic serial_clock_line, serial_data_out, serial_data_in;
  logic [12:0] ad [0:2];
  logic [7:0] ex [0:2];
  int err_total, n_compared, seed;
  sme_eeprom_master u_dut (
    .clk(clk),
    .rst(rst),
    .op_valid(op_valid),
    .op_ready(op_ready),
    .op_code(op_code),
    .op_addr(op_addr),
    .op_data(op_data),
    .op_fail(op_fail),
    .rd_valid(rd_valid),
    .rd_ready(rd_ready),
    .rd_data(rd_data),
    .tx_done_flag(tx_done_flag),
    .tx_buffer_empty_flag(tx_buffer_empty_flag),
    .chip_select_line_n(chip_select_line_n),
    .serial_clock_line(serial_clock_line),
    .serial_data_out(serial_data_out),
    .serial_data_in(serial_data_in)
  );
  sme_eeprom_model u_mem (
    .cs_n(chip_select_line_n),
    .sck(serial_clock_line),
    .din(serial_data_out),
    .latch_deaf(deaf),
    .dout(serial_data_in)
  );
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [7:0] stat_exp(input logic [7:0] d);
    return {d[7], 3'h0, d[3:2], 2'h0};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic idle;
    while (op_ready !== 1'b1) tick();
  endtask
  task automatic run(input logic [2:0] c, input logic [12:0] a,
                     input logic [7:0] d);
    idle();
    {op_valid, op_code, op_addr, op_data} = {1'b1, c, a, d};
    tick();
    op_valid = 1'b0;
  endtask
  task automatic pop(input logic [7:0] exp);
    while (rd_valid !== 1'b1) tick();
    check(rd_data, exp);
    rd_ready = 1'b1;
    tick();
    rd_ready = 1'b0;
    tick();
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    $display("ERROR %0t: watchdog expired", $time);
    conclude();
  end
  initial begin
    seed = 32'h1802;
    {rst, op_valid, rd_ready, deaf} = 4'h8;
    {op_code, op_addr, op_data} = '0;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    run(3'h3, 13'h0000, 8'h84);
    run(3'h2, 13'h0000, 8'h00);
    pop(stat_exp(8'h84));
    ad[0] = 13'h0000;
    ad[1] = 13'h1fff;
    ad[2] = {1'b0, 12'($random(seed))} | 13'h0001;
    for (int i = 0; i < 3; i++) begin
      ex[i] = 8'($random(seed));
      run(3'h0, ad[i], ex[i]);
    end
    idle();
    check({7'h0, op_fail}, 8'h00);
    // Top quarter protected: last address keeps its erased value
    ex[1] = 8'hff;
    $display("test write done");
    run(3'h3, 13'h0000, 8'h00);
    run(3'h4, 13'h0000, 8'h00);
    run(3'h2, 13'h0000, 8'h00);
    pop(8'h00);
    $display("test status done");
    deaf = 1'b1;
    run(3'h0, 13'h0005, 8'h5a);
    idle();
    check({7'h0, op_fail}, 8'h01);
    deaf = 1'b0;
    $display("test refusal done");
    for (int i = 0; i < 9; i++) run(3'h1, ad[i % 3], 8'($random(seed)));
    repeat (3500) tick();
    check({7'h0, op_ready}, 8'h00);
    for (int i = 0; i < 9; i++) pop(ex[i % 3]);
    $display("test fifo done");
    conclude();
  end
endmodule
